// ===== rtl/bus_driver_consts.vh
// constants for the bus driver interface logic
`ifndef BUS_DRIVER_CONSTS_VH
`define BUS_DRIVER_CONSTS_VH
// operating mode codes
`define MODE_AWAKE 3'h0
`define MODE_LISTEN 3'h1
`define MODE_XMIT 3'h2
`define MODE_SLEEP_ENTRY 3'h3
`define MODE_DEEP 3'h4
`define MODE_FAILSAFE 3'h5
// bus symbol drive codes on bus_drive
`define SYM_IDLE 2'h0
`define SYM_LOW 2'h1
`define SYM_HIGH 2'h2
// bias codes on bias_select
`define BIAS_OPEN 2'h0
`define BIAS_LEVEL 2'h1
`define BIAS_GROUND 2'h2
// default levels of unconnected inputs
`define DFLT_TXD 1'b0
`define DFLT_GATE_N 1'b1
`define DFLT_SEL_A 1'b0
`define DFLT_SEL_B 1'b0
`define DFLT_GUARD 1'b0
// sync stage depth
`define SYNC_STAGES 2
`endif

// ===== rtl/bus_driver_interface_logic.v
// digital interface logic of a differential bus transceiver
//
// What this block does
// - open gate or guardian pin disables transmitter
// - floating transmit data drives low symbol
// - both open selects give low power awake
// - unconnected inputs read their fixed defaults
// - low power modes ignore transmit side inputs
// - deep low power switches pull structures off
// - missing supply forces fail safe mode
// - bus idle outside transmit capable mode
// - transmit capable and listen bias to level
// - awake, deep, sleep entry bias to ground
// - unpowered leaves bias open
// - no reference: receive data low, tx defaults
// - enable needs mode, gate low, guardian high
// - gate activation only while data low
// - data high gives high symbol, low gives low
// - receive data follows bus symbol, idle high
// - low power: outputs low when wake flag set
// - no reference: activity low, guardian default
// - guardian low always blocks transmitter
// - activity flag low for any data symbol
// - selects map to the four mode choices
`timescale 1ns/100ps
`include "bus_driver_consts.vh"

module bus_driver_interface_logic
(
  // clock and reset
  input wire mclk,
  input wire srst,
  // controller side pins; connected flags model pin float detection
  input wire transmit_data,
  input wire transmit_data_conn,
  input wire transmit_gate_n,
  input wire transmit_gate_n_conn,
  // guardian pin
  input wire guardian_enable,
  input wire guardian_enable_conn,
  // mode select pins
  input wire mode_select_a,
  input wire mode_select_a_conn,
  input wire mode_select_b,
  input wire mode_select_b_conn,
  // supply monitors, high when present
  input wire supply_ok,
  input wire reference_supply_ok,
  input wire powered,
  // receiver results and wake flag
  input wire [1:0] bus_symbol,
  input wire wake_flag,
  // outputs toward partners
  output reg receive_data,
  output reg bus_activity_n,
  // analog control outputs
  output reg [1:0] bus_drive,
  output reg [1:0] bias_select,
  output reg pulls_enable,
  output reg [2:0] mode
);

  // raw levels with pin defaults applied where a pin floats
  wire pin_txd; // transmit data as seen at the pin
  wire pin_gate_n; // gate as seen at the pin
  wire pin_guard; // guardian as seen at the pin
  wire pin_sel_a; // select a as seen at the pin
  wire pin_sel_b; // select b as seen at the pin

  // pulls are off in deep sleep, but transmit side inputs are ignored there anyway
  assign pin_txd = transmit_data_conn ? transmit_data : `DFLT_TXD;
  assign pin_gate_n = transmit_gate_n_conn ? transmit_gate_n : `DFLT_GATE_N;
  assign pin_guard = guardian_enable_conn ? guardian_enable : `DFLT_GUARD;
  assign pin_sel_a = mode_select_a_conn ? mode_select_a : `DFLT_SEL_A;
  assign pin_sel_b = mode_select_b_conn ? mode_select_b : `DFLT_SEL_B;

  // settled levels, each the last stage of its synchroniser
  wire sync_txd; // transmit data
  wire sync_gate_n; // transmit gate, active low
  wire sync_guard; // guardian enable
  wire sync_sel_a; // mode select a
  wire sync_sel_b; // mode select b
  wire sync_ref; // reference supply present
  wire sync_sup; // main supplies present
  wire sync_pwr; // any supply present
  wire sync_wake; // wake flag level
  wire [1:0] sync_sym1; // receiver symbol

  // one chain per pin; reset loads the level of a floating pin, so
  // nothing after reset looks as if a pin had just been pulled
  // transmit data chain
  sync_chain #(.WIDTH(1), .INIT(`DFLT_TXD)) u_sync_txd
  (
    .mclk(mclk),
    .srst(srst),
    .d(pin_txd),
    .q(sync_txd)
  );
  // transmit gate chain, idles high
  sync_chain #(.WIDTH(1), .INIT(`DFLT_GATE_N)) u_sync_gate_n
  (
    .mclk(mclk),
    .srst(srst),
    .d(pin_gate_n),
    .q(sync_gate_n)
  );
  // guardian enable chain, idles low
  sync_chain #(.WIDTH(1), .INIT(`DFLT_GUARD)) u_sync_guard
  (
    .mclk(mclk),
    .srst(srst),
    .d(pin_guard),
    .q(sync_guard)
  );
  // mode select a chain
  sync_chain #(.WIDTH(1), .INIT(`DFLT_SEL_A)) u_sync_sel_a
  (
    .mclk(mclk),
    .srst(srst),
    .d(pin_sel_a),
    .q(sync_sel_a)
  );
  // mode select b chain
  sync_chain #(.WIDTH(1), .INIT(`DFLT_SEL_B)) u_sync_sel_b
  (
    .mclk(mclk),
    .srst(srst),
    .d(pin_sel_b),
    .q(sync_sel_b)
  );
  // reference monitor; reads missing until settled, so fail safe first
  sync_chain #(.WIDTH(1), .INIT(1'h0)) u_sync_ref
  (
    .mclk(mclk),
    .srst(srst),
    .d(reference_supply_ok),
    .q(sync_ref)
  );
  // main supply monitor
  sync_chain #(.WIDTH(1), .INIT(1'h0)) u_sync_sup
  (
    .mclk(mclk),
    .srst(srst),
    .d(supply_ok),
    .q(sync_sup)
  );
  // any supply monitor
  sync_chain #(.WIDTH(1), .INIT(1'h0)) u_sync_pwr
  (
    .mclk(mclk),
    .srst(srst),
    .d(powered),
    .q(sync_pwr)
  );
  // wake flag chain
  sync_chain #(.WIDTH(1), .INIT(1'h0)) u_sync_wake
  (
    .mclk(mclk),
    .srst(srst),
    .d(wake_flag),
    .q(sync_wake)
  );
  // receiver symbol; both bits may skew, a torn code lasts one cycle
  sync_chain #(.WIDTH(2), .INIT(`SYM_IDLE)) u_sync_sym
  (
    .mclk(mclk),
    .srst(srst),
    .d(bus_symbol),
    .q(sync_sym1)
  );

  // synchronised views
  wire ref_ok = sync_ref; // reference supply present
  wire sup_ok = sync_sup; // main supplies present
  wire pwr_ok = sync_pwr; // device powered at all
  wire wake_set = sync_wake; // wake flag level
  // missing reference forces each controller, guardian and select pin to its default level
  wire s_txd = ref_ok ? sync_txd : `DFLT_TXD;
  wire s_gate_n = ref_ok ? sync_gate_n : `DFLT_GATE_N;
  wire s_guard = ref_ok ? sync_guard : `DFLT_GUARD;
  wire s_sel_a = ref_ok ? sync_sel_a : `DFLT_SEL_A;
  wire s_sel_b = ref_ok ? sync_sel_b : `DFLT_SEL_B;

  // mode decode and transmitter enable state
  reg [2:0] next_mode;
  reg tx_on; // transmitter currently activated
  reg next_tx_on;
  reg [1:0] next_drive;
  reg [1:0] next_bias;
  reg next_rxd;
  reg next_act_n;

  // mode register codes, binary, shared with the header so the bench
  // and the checker read the same numbers
  localparam [2:0] ST_AWAKE = `MODE_AWAKE; // low power awake
  localparam [2:0] ST_LISTEN = `MODE_LISTEN; // receive only
  localparam [2:0] ST_XMIT = `MODE_XMIT; // transmit capable
  localparam [2:0] ST_SLEEP_ENTRY = `MODE_SLEEP_ENTRY; // one cycle on the way down
  localparam [2:0] ST_DEEP = `MODE_DEEP; // deep low power
  localparam [2:0] ST_FAILSAFE = `MODE_FAILSAFE; // some supply missing

  // mode selection from the select pins and supply state; a missing
  // supply outranks any host command
  always @*
  begin
    next_mode = ST_AWAKE; // pulled-down selects land here
    if (!pwr_ok || !sup_ok || !ref_ok)
    begin
      next_mode = ST_FAILSAFE;
    end
    else
    begin
      case ({s_sel_a, s_sel_b})
        2'b11:
          next_mode = ST_XMIT; // both high
        2'b10:
          next_mode = ST_LISTEN; // select a only
        2'b01:
        begin
          // sleep entry lasts one cycle, then deep low power; a held
          // command keeps the device down instead of cycling
          if (mode == ST_SLEEP_ENTRY || mode == ST_DEEP)
            next_mode = ST_DEEP;
          else
            next_mode = ST_SLEEP_ENTRY;
        end
        default:
          next_mode = ST_AWAKE;
      endcase
    end
  end

  // transmitter gating; data low is needed only at activation
  always @*
  begin
    next_tx_on = 1'b0;
    if (next_mode == `MODE_XMIT && !s_gate_n && s_guard)
      next_tx_on = tx_on || !s_txd;
  end

  // bus symbol from transmit data while enabled, idle otherwise
  always @*
  begin
    next_drive = `SYM_IDLE;
    if (next_tx_on)
      next_drive = s_txd ? `SYM_HIGH : `SYM_LOW;
  end

  // bias per mode
  always @*
  begin
    case (next_mode)
      `MODE_XMIT, `MODE_LISTEN: next_bias = `BIAS_LEVEL;
      `MODE_AWAKE, `MODE_DEEP, `MODE_SLEEP_ENTRY: next_bias = `BIAS_GROUND;
      default: next_bias = `BIAS_OPEN;
    endcase
    // fail safe with power still present grounds the bus
    if (next_mode == `MODE_FAILSAFE && pwr_ok)
      next_bias = `BIAS_GROUND;
    if (!pwr_ok)
      next_bias = `BIAS_OPEN;
  end

  // receive outputs: low without reference, bus symbol in active modes, wake flag otherwise
  always @*
  begin
    next_rxd = 1'b1;
    next_act_n = 1'b1;
    if (!ref_ok)
    begin
      next_rxd = 1'b0;
      next_act_n = 1'b0;
    end
    else if (next_mode == `MODE_XMIT || next_mode == `MODE_LISTEN)
    begin
      next_rxd = (sync_sym1 != `SYM_LOW);
      next_act_n = (sync_sym1 == `SYM_IDLE);
    end
    else
    begin
      next_rxd = !wake_set;
      next_act_n = !wake_set;
    end
  end

  // output and state registers
  always @(posedge mclk)
  begin
    if (srst)
    begin
      mode <= `MODE_AWAKE;
      tx_on <= 1'b0;
      bus_drive <= `SYM_IDLE;
      bias_select <= `BIAS_OPEN;
      pulls_enable <= 1'b1;
      receive_data <= 1'b1;
      bus_activity_n <= 1'b1;
    end
    else
    begin
      mode <= next_mode;
      tx_on <= next_tx_on;
      bus_drive <= next_drive;
      bias_select <= next_bias;
      pulls_enable <= (next_mode != `MODE_DEEP);
      receive_data <= next_rxd;
      bus_activity_n <= next_act_n;
    end
  end

endmodule

// two flop synchroniser shared by every pin input
module sync_chain
#(
  parameter WIDTH = 1, // bits carried side by side
  parameter STAGES = `SYNC_STAGES, // flops in series, two at least
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}} // level loaded by reset
)
(
  // clock and reset
  input wire mclk,
  input wire srst,
  // asynchronous level in, settled level out
  input wire [WIDTH-1:0] d,
  output wire [WIDTH-1:0] q
);

  // stage 0 sits in the low bits and is read only by the next stage
  reg [WIDTH*STAGES-1:0] chain;

  // a single flop would pass a metastable level straight into the
  // mode logic; the second stage buys a full cycle to settle
  always @(posedge mclk)
  begin
    if (srst)
      chain <= {STAGES{INIT}}; // reset to the idle level of the pin
    else
      chain <= {chain[WIDTH*(STAGES-1)-1:0], d};
  end

  // only the last stage leaves the chain
  assign q = chain[WIDTH*STAGES-1 -: WIDTH];

endmodule

// ===== test/bus_driver_chk.sv
// port checker for the bus driver interface logic
`timescale 1ns/100ps
`include "bus_driver_consts.vh"
module bus_driver_chk (
  // clock, reset and pins
  input wire mclk,
  input wire srst,
  input wire transmit_data_conn,
  input wire guardian_enable,
  input wire reference_supply_ok,
  input wire wake_flag,
  input wire [1:0] bus_symbol,
  // outputs
  input wire receive_data,
  input wire bus_activity_n,
  input wire [1:0] bus_drive,
  input wire [1:0] bias_select,
  input wire pulls_enable,
  input wire [2:0] mode
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  // three samples span the two sync flops and the output flop
  sequence s_guard_off; !guardian_enable [*3]; endsequence
  sequence s_ref_gone; !reference_supply_ok [*3]; endsequence
  sequence s_data_open; (!transmit_data_conn) [*4]; endsequence
  a_guard_blocks:
    assert property (s_guard_off |=> bus_drive == `SYM_IDLE) else $error("guard low, bus driven");
  a_ref_lost:
    assert property (s_ref_gone |=> mode == `MODE_FAILSAFE && !receive_data && !bus_activity_n)
    else $error("reference lost, outputs not forced");
  a_float_low:
    assert property (s_data_open ##0 bus_drive != `SYM_IDLE |-> bus_drive == `SYM_LOW)
    else $error("floating data not sent low");
  // two samples so a mode change never races the drive flop
  a_idle_off_mode:
    assert property ((mode != `MODE_XMIT) [*2] |-> bus_drive == `SYM_IDLE) else $error("bus driven");
  a_bias_level:
    assert property ((mode inside {`MODE_XMIT, `MODE_LISTEN}) [*2] |-> bias_select == `BIAS_LEVEL)
    else $error("bias not at level");
  a_deep_pulls:
    assert property ((mode == `MODE_DEEP) [*2] |-> !pulls_enable) else $error("pulls on in deep");
  a_rx_low:
    assert property ((bus_symbol == `SYM_LOW) [*4] ##0 mode inside {`MODE_LISTEN, `MODE_XMIT}
      |-> !receive_data && !bus_activity_n) else $error("low symbol not reported");
  a_wake_shown:
    assert property (wake_flag [*4] ##0 mode == `MODE_AWAKE |-> !receive_data && !bus_activity_n)
    else $error("wake flag not shown");
  a_entry_ground:
    assert property (mode == `MODE_SLEEP_ENTRY |-> bias_select == `BIAS_GROUND)
    else $error("sleep entry not grounded");
  // a transfer opens only from idle, and then with the low symbol
  sequence s_tx_start; $past(bus_drive) == `SYM_IDLE ##0 bus_drive != `SYM_IDLE; endsequence
  a_start_low:
    assert property (s_tx_start |-> bus_drive == `SYM_LOW) else $error("transfer opened high");
endmodule

// ===== test/bus_partner.sv
// bus medium model: own symbol echoed, else a remote node's symbol
`timescale 1ns/100ps
`include "bus_driver_consts.vh"
module bus_partner (
  // clock
  input wire mclk,
  // own drive and remote traffic in, receiver symbol out
  input wire [1:0] bus_drive,
  input wire [1:0] remote_symbol,
  output logic [1:0] bus_symbol = `SYM_IDLE
);
  // own drive wins; remote traffic only shows on an idle line
  always @(posedge mclk)
    bus_symbol <= bus_drive != `SYM_IDLE ? bus_drive : remote_symbol;
endmodule

// ===== test/tb_top.sv
// self-checking bench for the bus driver interface logic
`timescale 1ns/100ps
`include "bus_driver_consts.vh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module tb_top;
  // pins, all driven on the rising edge
  logic mclk = 0, srst = 1, transmit_data = 0, transmit_gate_n = 1, guardian_enable = 0;
  logic mode_select_a = 0, mode_select_b = 0, supply_ok = 1, reference_supply_ok = 1;
  logic powered = 1, wake_flag = 0, transmit_data_conn = 1, transmit_gate_n_conn = 1;
  logic guardian_enable_conn = 1, mode_select_a_conn = 1, mode_select_b_conn = 1;
  logic [1:0] remote_symbol = 2'h0, bus_symbol, bus_drive, bias_select;
  logic [2:0] mode;
  logic receive_data, bus_activity_n, pulls_enable;
  int n_fail = 0, cmp_count = 0;
  bus_driver_interface_logic u_dut (.*);
  bus_partner u_bus (.*);
  initial forever #5 mclk = ~mclk;
  // verdict and end of run
  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // expected mode from the pin picture, long after any sleep entry
  function automatic logic [2:0] exp_mode();
    logic [2:0] m;
    m = mode_select_a & mode_select_a_conn ? `MODE_LISTEN : `MODE_AWAKE;
    if (mode_select_b & mode_select_b_conn)
      m = m == `MODE_LISTEN ? `MODE_XMIT : `MODE_DEEP;
    if (!supply_ok || !reference_supply_ok || !powered)
      m = `MODE_FAILSAFE;
    return m;
  endfunction
  // expected drive: only a fully enabled transmit mode drives the bus
  function automatic logic [1:0] exp_drive(input logic [2:0] m);
    logic [1:0] d;
    d = transmit_data & transmit_data_conn ? `SYM_HIGH : `SYM_LOW;
    if (m != `MODE_XMIT || !(guardian_enable & guardian_enable_conn) || transmit_gate_n
        || !transmit_gate_n_conn)
      d = `SYM_IDLE;
    return d;
  endfunction
  // wait out the sync flops, then compare with the pin picture
  task automatic settle();
    logic [2:0] m;
    logic [1:0] d, s, b;
    logic lp, r;
    repeat (8) @(posedge mclk);
    #1;
    m = exp_mode();
    d = exp_drive(m);
    s = d == `SYM_IDLE ? remote_symbol : d;
    lp = m != `MODE_XMIT && m != `MODE_LISTEN;
    b = lp ? (powered ? `BIAS_GROUND : `BIAS_OPEN) : `BIAS_LEVEL;
    `CHK("mode", m, mode)
    `CHK("drive", d, bus_drive)
    `CHK("bias", b, bias_select)
    r = lp ? reference_supply_ok & !wake_flag : s != `SYM_LOW;
    `CHK("rxd", r, receive_data)
    r = lp ? reference_supply_ok & !wake_flag : s == `SYM_IDLE;
    `CHK("act_n", r, bus_activity_n)
    `CHK("pulls", m != `MODE_DEEP, pulls_enable)
  endtask
  // one edge sets {conn x5, remote, wake, sel a, sel b, gate_n, guard, data}
  task automatic put(input logic [12:0] v);
    @(posedge mclk);
    {transmit_data_conn, transmit_gate_n_conn, guardian_enable_conn, mode_select_a_conn,
     mode_select_b_conn, remote_symbol, wake_flag, mode_select_a, mode_select_b,
     transmit_gate_n, guardian_enable, transmit_data} <= v;
    settle();
  endtask
  // hang guard, about five times the expected run
  initial
  begin
    #20us;
    n_fail++;
    conclude();
  end
  initial
  begin
    void'($urandom(70));
    repeat (19) @(posedge mclk);
    #1;
    `CHK("reset", 10'h007, {mode, bus_drive, bias_select, pulls_enable, receive_data, bus_activity_n})
    @(posedge mclk);
    srst <= 0;
    put({5'h00, 8'h3f});
    put({5'h00, 8'h1f});
    $display("test defaults done");
    // gate held off in transmit mode so data order stays legal
    for (int i = 0; i < 16; i++)
      put({5'h1f, 2'($urandom_range(2)), 1'($urandom), 2'(i),
           1'(i % 4 == 3 || $urandom % 2 == 1), 2'($urandom)});
    $display("test modes done");
    put({5'h1f, 8'h1a});
    for (int i = 0; i < 12; i++)
      put({5'h1f, 7'h0d, 1'($urandom)});
    put({5'h0f, 8'h1b});
    put({5'h1f, 8'h18});
    put({5'h1f, 8'h1a});
    put({5'h17, 8'h1a});
    put({5'h1b, 8'h1a});
    put({5'h1f, 8'h1e});
    @(posedge mclk);
    {transmit_gate_n, transmit_data} <= 2'h1;
    repeat (8) @(posedge mclk);
    #1;
    `CHK("refused", `SYM_IDLE, bus_drive)
    put({5'h1f, 8'h1a});
    $display("test transmit done");
    @(posedge mclk);
    reference_supply_ok <= 0;
    put({5'h1f, 8'h1a});
    @(posedge mclk);
    {supply_ok, powered} <= 2'h0;
    put({5'h1f, 8'h1a});
    @(posedge mclk);
    {supply_ok, powered, reference_supply_ok} <= 3'h7;
    put({5'h1f, 8'h1a});
    $display("test supplies done");
    conclude();
  end
endmodule
bind bus_driver_interface_logic bus_driver_chk u_chk (.mclk, .srst, .transmit_data_conn,
  .guardian_enable, .reference_supply_ok, .wake_flag, .bus_symbol, .receive_data,
  .bus_activity_n, .bus_drive, .bias_select, .pulls_enable, .mode);
